// file: design/fprc_top.sv
// Front panel run control: stop, step, slow run, reset, protect and the
// sequence-program start. Switches and bus status are asynchronous pins.
// Function
// [RULE1] Stop flop is clocked only on status bit five, sync and strobe
// [RULE2] While stopped, the other panel switches are enabled
// [RULE3] Stop flop stays set after the stop switch is released
// [RULE4] While stopped, run and panel ready are both low
// [RULE5] Step request sets the step flop, which raises panel ready
// [RULE6] Next instruction start clears the step flop
// [RULE7] Without the jumpers, sync and strobe alone clear the step flop
// [RULE8] In slow mode the slow tick sets the step flop
// [RULE9] Slow mode keeps stepping on each tick until deselected
// [RULE10] Reset request is taken any time and driven to bus reset
// [RULE11] Protect and unprotect each drive their own bus line
// [RULE12] Protected memory rejects writes until unprotected
// [RULE13] Each of eight operations sets its own upper sequence address
// [RULE14] Starting an operation clears the low step counter to zero
// [RULE15] Stop switch passes two panel-clock latch stages
// [RULE16] Even word loads control latch; odd word is offered to processor
// [RULE17] Halt word stops the step counter
// [RULE18] Switches are panel-clock synchronised; momentary ones act on edges
`timescale 1ns/1ps
`default_nettype none
module fprc_top #(
  parameter int PANEL_TICK_CYC = fprc_pkg::PANEL_TICK_CYC,
  parameter int SLOW_TICK_DIV  = fprc_pkg::SLOW_TICK_DIV
) (
  input  wire logic       ref_clk,              // 25 MHz clock
  input  wire logic       reset,                // sync reset, active high
  input  wire logic       stop_sw,              // stop switch, high = pressed
  input  wire logic       run_sw,               // run switch
  input  wire logic       step_sw,              // single step switch
  input  wire logic       slow_sw,              // slow mode selected
  input  wire logic       reset_sw,             // reset switch
  input  wire logic       protect_sw,           // protect switch
  input  wire logic       unprotect_sw,         // unprotect switch
  input  wire logic [7:0] op_sw,                // eight sequence operations
  input  wire logic       status_bit_five,      // processor status bit five
  input  wire logic       cycle_sync,           // machine cycle sync
  input  wire logic       status_strobe,        // status strobe, high true
  input  wire logic       status_gate_jumper_a, // jumper a fitted
  input  wire logic       status_gate_jumper_b, // jumper b fitted
  input  wire logic       seq_load_en,          // sequence store write
  input  wire logic [7:0] seq_load_addr,        // store write address
  input  wire logic [7:0] seq_load_data,        // store write data
  output logic            run,                  // processor running
  output logic            panel_ready,          // ready to processor
  output logic            switch_enable,        // panel switches enabled
  output logic            step_active,          // step flop state
  output logic            bus_reset,            // reset to bus
  output logic            protect_line,         // protect to memory
  output logic            unprotect_line,       // unprotect to memory
  output logic [3:0]      seq_addr_high,        // upper sequence address
  output logic [3:0]      seq_addr_low,         // step counter
  output logic            seq_busy,             // program running
  output logic [7:0]      ctrl_latch,           // control latch
  output logic [7:0]      jam_data,             // word offered to processor
  output logic            jam_valid,            // jam_data is offered
  output logic            panel_tick,           // panel clock pulse
  output logic            slow_tick             // slow step pulse
);

  localparam int PW = $clog2(PANEL_TICK_CYC) + 1;
  localparam int DW = fprc_pkg::DIV_W;
  localparam int N  = fprc_pkg::SW_N;

  function automatic logic [3:0] op_code(input logic [7:0] sel);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 7; i >= 0; i--)
      if (sel[i]) c = fprc_pkg::OP_CODE[i];
    return c;
  endfunction

  // Pin synchronisers and panel clock stages
  logic [N-1:0]  sw_m_q, sw_s_q, pnl1_q, pnl2_q, pnl3_q;
  logic [4:0]    st_m_q, st_s_q;
  logic [PW-1:0] presc_q;
  logic [DW-1:0] div_q;
  logic          tick_q, tick_dly_q, slow_q;
  logic [2:0]    coin_q;

  wire [N-1:0] sw_raw = {op_sw, unprotect_sw, protect_sw, reset_sw,
                         slow_sw, step_sw, run_sw, stop_sw};
  wire [4:0] st_raw = {status_gate_jumper_b, status_gate_jumper_a,
                       status_strobe, cycle_sync, status_bit_five};

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sw_m_q <= '0;
      sw_s_q <= '0;
      st_m_q <= '0;
      st_s_q <= '0;
    end else begin
      sw_m_q <= sw_raw;
      sw_s_q <= sw_m_q;
      st_m_q <= st_raw;
      st_s_q <= st_m_q;
    end
  end

  wire presc_end = presc_q == PW'(PANEL_TICK_CYC - 1);
  wire div_end   = div_q == DW'(SLOW_TICK_DIV - 1);

  // Free-running panel clock and the divider that yields the slow tick
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      presc_q    <= '0;
      div_q      <= '0;
      tick_q     <= 1'b0;
      tick_dly_q <= 1'b0;
      slow_q     <= 1'b0;
    end else begin
      presc_q    <= presc_end ? '0 : presc_q + 1'b1;
      tick_q     <= presc_end;
      tick_dly_q <= tick_q;
      if (tick_q) div_q <= div_end ? '0 : div_q + 1'b1;
      slow_q     <= tick_q && div_end; // RULE8
    end
  end

  // Two panel-clock stages, then a third to find the press edge
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pnl1_q <= '0;
      pnl2_q <= '0;
      pnl3_q <= '0;
    end else if (tick_q) begin
      pnl1_q <= sw_s_q;                    // RULE18
      pnl2_q <= pnl1_q;                    // RULE15
      pnl3_q <= pnl2_q;
    end
  end

  // One-cycle request per press, seen just after the panel tick
  wire [N-1:0] sw_edge = pnl2_q & ~pnl3_q & {N{tick_dly_q}}; // RULE18

  // Bus status coincidence; the jumpers gate status bit five for stepping
  wire jumper_in = st_s_q[3] & st_s_q[4];
  wire coin_all  = st_s_q[1] & st_s_q[2];
  wire coin_m1   = coin_all & st_s_q[0];
  wire coin_step = coin_all & (jumper_in ? st_s_q[0] : 1'b1);  // RULE7
  wire cyc_edge  = coin_all & ~coin_q[0];
  wire m1_edge   = coin_m1 & ~coin_q[1];
  wire step_edge = coin_step & ~coin_q[2];

  always_ff @(posedge ref_clk) begin
    if (reset) coin_q <= '0;
    else coin_q <= {coin_step, coin_m1, coin_all};
  end

  // Stop and step flops
  logic stop_q, step_q;
  wire  stop_req = pnl2_q[fprc_pkg::SW_STOP];
  wire  stop_set = stop_req & m1_edge;                         // RULE1
  wire  slow_lvl = pnl2_q[fprc_pkg::SW_SLOW];                  // RULE9
  wire  step_set = stop_q & (sw_edge[fprc_pkg::SW_STEP] |
                             (slow_lvl & slow_q));             // RULE2
  wire  stop_d   = stop_set | (stop_q & ~sw_edge[fprc_pkg::SW_RUN]); // RULE3
  wire  step_d   = step_set | (step_q & ~step_edge);           // RULE6

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stop_q <= 1'b0;
      step_q <= 1'b0;
    end else begin
      stop_q <= stop_d;
      step_q <= step_d;                                        // RULE5
    end
  end

  // Sequence program selector
  fprc_store_if #(.AW(fprc_pkg::SEQ_AW), .DW(fprc_pkg::SEQ_DW)) st ();

  fprc_seq_store #(.AW(fprc_pkg::SEQ_AW), .DW(fprc_pkg::SEQ_DW)) u_store (
    .ref_clk (ref_clk),
    .reset   (reset),
    .st      (st.store)
  );

  fprc_pkg::fprc_seq_state_t state_q, state_d;
  logic [3:0] hi_q, hi_d, lo_q, lo_d;
  logic [7:0] ctrl_q, ctrl_d, jam_q, jam_d;
  logic       jv_q, jv_d;

  wire [7:0] op_edge   = sw_edge[fprc_pkg::SW_OP0 +: 8];
  wire       seq_start = stop_q & (state_q == fprc_pkg::SEQ_IDLE)
                         & (|op_edge);
  wire [7:0] word      = st.rd_data;
  wire       seq_rdy   = ctrl_q[fprc_pkg::CTL_S8_BIT]
                         & (state_q == fprc_pkg::SEQ_CYCLE);

  assign st.rd_addr = {hi_q, lo_q};
  assign st.wr_en   = seq_load_en;
  assign st.wr_addr = seq_load_addr;
  assign st.wr_data = seq_load_data;

  always_comb begin
    state_d = state_q;
    hi_d    = hi_q;
    lo_d    = lo_q;
    ctrl_d  = ctrl_q;
    jam_d   = jam_q;
    jv_d    = jv_q;
    unique case (state_q)
      fprc_pkg::SEQ_IDLE: begin
        if (seq_start) begin
          hi_d    = op_code(op_edge);                          // RULE13
          lo_d    = 4'h0;                                      // RULE14
          state_d = fprc_pkg::SEQ_READ;
        end
      end
      fprc_pkg::SEQ_READ: state_d = fprc_pkg::SEQ_WORD;
      fprc_pkg::SEQ_WORD: begin
        if (word == fprc_pkg::HALT_WORD) begin
          state_d = fprc_pkg::SEQ_IDLE;                        // RULE17
        end else if (!lo_q[0]) begin
          ctrl_d  = word;                                      // RULE16
          lo_d    = lo_q + 4'h1;
          state_d = fprc_pkg::SEQ_READ;
        end else begin
          jam_d   = word;                                      // RULE16
          jv_d    = 1'b1;
          state_d = fprc_pkg::SEQ_CYCLE;
        end
      end
      fprc_pkg::SEQ_CYCLE: begin
        // The processor's next cycle sync marks the end of this cycle
        if (cyc_edge) begin
          jv_d    = 1'b0;
          lo_d    = lo_q + 4'h1;
          state_d = fprc_pkg::SEQ_READ;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= fprc_pkg::SEQ_IDLE;
      hi_q    <= 4'h0;
      lo_q    <= 4'h0;
      ctrl_q  <= fprc_pkg::CTL_RST;
      jam_q   <= 8'h00;
      jv_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      hi_q    <= hi_d;
      lo_q    <= lo_d;
      ctrl_q  <= ctrl_d;
      jam_q   <= jam_d;
      jv_q    <= jv_d;
    end
  end

  // Registered outputs
  logic run_q, rdy_q, bres_q, prot_q, unprot_q, busy_q;
  wire  prot_lvl   = pnl2_q[fprc_pkg::SW_PROT];
  wire  unprot_lvl = pnl2_q[fprc_pkg::SW_UNPROT];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      run_q    <= 1'b0;
      rdy_q    <= 1'b0;
      bres_q   <= 1'b0;
      prot_q   <= 1'b0;
      unprot_q <= 1'b0;
      busy_q   <= 1'b0;
    end else begin
      run_q    <= ~stop_d;                                     // RULE4
      rdy_q    <= ~stop_d | step_d | seq_rdy;                  // RULE4
      bres_q   <= pnl2_q[fprc_pkg::SW_RESET];                  // RULE10
      prot_q   <= stop_q & prot_lvl & ~unprot_lvl;             // RULE11
      unprot_q <= stop_q & unprot_lvl & ~prot_lvl;             // RULE11
      busy_q   <= state_d != fprc_pkg::SEQ_IDLE;
    end
  end

  assign run            = run_q;
  assign panel_ready    = rdy_q;
  assign switch_enable  = stop_q;                              // RULE2
  assign step_active    = step_q;
  assign bus_reset      = bres_q;
  assign protect_line   = prot_q;
  assign unprotect_line = unprot_q;
  assign seq_addr_high  = hi_q;
  assign seq_addr_low   = lo_q;
  assign seq_busy       = busy_q;
  assign ctrl_latch     = ctrl_q;
  assign jam_data       = jam_q;
  assign jam_valid      = jv_q;
  assign panel_tick     = tick_q;
  assign slow_tick      = slow_q;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_stop_on_m1: assert property ( // RULE1
    $rose(stop_q) |-> $past(m1_edge) && $past(stop_req))
    else $error("stop flop set outside first machine cycle");
  a_stop_holds: assert property ( // RULE3
    stop_q && !sw_edge[fprc_pkg::SW_RUN] |=> stop_q)
    else $error("stop flop dropped without run request");
  a_step_gated: assert property ( // RULE2
    $rose(step_q) |-> $past(stop_q))
    else $error("step taken while switches disabled");
  a_stop_waits: assert property ( // RULE4
    stop_q && !step_q && !seq_rdy && !step_set && !sw_edge[fprc_pkg::SW_RUN]
    |=> !panel_ready && !run)
    else $error("processor not held while stopped");
  a_step_ready: assert property ( // RULE5
    $rose(step_q) |=> panel_ready)
    else $error("panel ready not raised by step");
  a_step_clear: assert property ( // RULE6
    step_q && jumper_in && m1_edge && !step_set |=> !step_q ##1 !step_q)
    else $error("step flop not cleared at next instruction");
  a_step_cycle: assert property ( // RULE7
    step_q && !jumper_in && cyc_edge && !step_set |=> !step_q)
    else $error("step flop not cleared per machine cycle");
  a_slow_step: assert property ( // RULE8
    stop_q && slow_lvl && slow_q |=> step_q)
    else $error("slow tick did not start a step");
  a_reset_line: assert property ( // RULE10
    pnl2_q[fprc_pkg::SW_RESET] |=> bus_reset)
    else $error("reset request not driven to bus");
  a_prot_excl: assert property ( // RULE11
    !(protect_line && unprotect_line))
    else $error("protect and unprotect both driven");
  a_seq_start: assert property ( // RULE14
    seq_start |=> seq_addr_low == 4'h0 && seq_busy
                  && seq_addr_high == $past(op_code(op_edge)))
    else $error("sequence start address wrong");
  a_seq_halt: assert property ( // RULE17
    state_q == fprc_pkg::SEQ_WORD && word == fprc_pkg::HALT_WORD
    |=> !seq_busy && $stable(seq_addr_low))
    else $error("halt word did not stop the counter");
  a_stop_stages: assert property ( // RULE15
    $rose(stop_req) |-> $past(pnl1_q[fprc_pkg::SW_STOP]) && $past(tick_q))
    else $error("stop request skipped a panel stage");

  c_step_done: cover property ($rose(step_q) ##[1:1000] $fell(step_q));
  c_stopped:   cover property ($rose(stop_q));
  c_seq_jam:   cover property ($rose(jam_valid) ##[1:1000] !seq_busy);

endmodule // fprc_top
`default_nettype wire

// file: common/fprc_pkg.sv
// Constants shared by the front panel run control and its sequence store.
// Assumes a single 25 MHz clock; all times are turned into clock-cycle or panel-tick counts here.
package fprc_pkg;

  localparam int CLK_PERIOD_NS  = 40;
  // Panel clock period; longest time, so the count rounds down
  localparam int PANEL_TICK_NS  = 20000;
  localparam int PANEL_TICK_CYC = PANEL_TICK_NS / CLK_PERIOD_NS;
  // Slow-run step period, counted in panel ticks by the 24-bit divider
  localparam int SLOW_TICK_MS   = 786;
  localparam int SLOW_TICK_DIV  = SLOW_TICK_MS * 1000000 / PANEL_TICK_NS;
  localparam int DIV_W          = 24;

  // Bit positions in the synchronised switch vector
  localparam int SW_STOP   = 0;
  localparam int SW_RUN    = 1;
  localparam int SW_STEP   = 2;
  localparam int SW_SLOW   = 3;
  localparam int SW_RESET  = 4;
  localparam int SW_PROT   = 5;
  localparam int SW_UNPROT = 6;
  localparam int SW_OP0    = 7;
  localparam int SW_N      = 15;

  // Upper sequence address per operation: examine, examine next, deposit,
  // deposit next, accumulator display, load, input, output
  localparam logic [3:0] OP_CODE [8] = '{4'h7, 4'hb, 4'hd, 4'he,
                                         4'h3, 4'h9, 4'hc, 4'ha};

  localparam logic [7:0] HALT_WORD  = 8'h7f;
  localparam logic [7:0] CTL_RST    = 8'h00;
  localparam int         CTL_S8_BIT = 0;
  localparam int         CTL_S7_BIT = 1;
  localparam int         SEQ_AW     = 8;
  localparam int         SEQ_DW     = 8;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_READ,
    SEQ_WORD,
    SEQ_CYCLE
  } fprc_seq_state_t;

endpackage

// file: common/fprc_store_if.sv
// Link between the run control and its sequence store.
// Read data arrive one clock after the address; writes take one clock.
`timescale 1ns/1ps
`default_nettype none
interface fprc_store_if #(
  parameter int AW = 8,
  parameter int DW = 8
) ();
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;

  modport ctrl  (output rd_addr, wr_en, wr_addr, wr_data, input rd_data);
  modport store (input rd_addr, wr_en, wr_addr, wr_data, output rd_data);
endinterface
`default_nettype wire

// file: design/fprc_seq_store.sv
// Sequence store: small RAM holding the panel's stored programs.
// Assumes the owner loads it before use; contents are undefined until then.
`timescale 1ns/1ps
`default_nettype none
module fprc_seq_store #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic    ref_clk,  // 25 MHz clock
  input  wire logic    reset,    // synchronous, active high
  fprc_store_if.store  st        // read and load port
);

  logic [DW-1:0] mem_q [2**AW];
  logic [DW-1:0] rd_q;

  always_ff @(posedge ref_clk) begin
    if (st.wr_en) begin
      mem_q[st.wr_addr] <= st.wr_data;
    end
  end

  // Registered read keeps the store a plain synchronous RAM
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_q <= '0;
    end else begin
      rd_q <= mem_q[st.rd_addr];
    end
  end

  assign st.rd_data = rd_q;

endmodule // fprc_seq_store
`default_nettype wire

// file: dv/fprc_cpu_model.sv
// Behavioural processor and memory board on the far side of the panel.
// Assumes one clock; each machine cycle is T_END+1 clocks plus any wait for ready at T_RDY, with a frame.
`timescale 1ns/1ps
`default_nettype none
module fprc_cpu_model #(
  parameter int T_RDY = 6, // Clock in the cycle where ready is sampled
  parameter int T_END = 7  // Last clock of a machine cycle
) (
  input  wire logic        ref_clk,         // 25 MHz clock
  input  wire logic        reset,           // sync reset, active high
  input  wire logic        panel_ready,     // ready from the panel
  input  wire logic        bus_reset,       // reset line from the bus
  input  wire logic        protect_line,    // protect to memory
  input  wire logic        unprotect_line,  // unprotect to memory
  input  wire logic        wr_req,          // write attempt to memory
  input  wire logic [7:0]  wr_data,         // data of that write
  output logic             status_bit_five, // first machine cycle flag
  output logic             cycle_sync,      // machine cycle sync
  output logic             status_strobe,   // status strobe
  output logic [1:0]       mc_idx,          // machine cycle in instruction
  output logic [15:0]      mcycles,         // completed machine cycles
  output logic [7:0]       mem_byte         // one protected memory byte
);
  logic [3:0] t_q;
  logic       ready_in;
  logic       noise_q;
  logic       prot_q;
  logic       in_frame;

  assign ready_in = panel_ready;
  assign in_frame = (t_q < 4'h2);
  assign cycle_sync = in_frame;
  assign status_strobe = in_frame;
  // Outside a frame the status line is stale, so it must not look stable
  assign status_bit_five = in_frame ? (mc_idx == 2'h0) : noise_q;

  always_ff @(posedge ref_clk) begin
    noise_q <= reset ? 1'b0 : ~noise_q;
    if (reset) begin
      mcycles <= 16'h0000;
    end else if (t_q == T_END[3:0]) begin
      mcycles <= mcycles + 16'h0001;
    end
    if (reset || bus_reset) begin
      t_q <= 4'h0;
      mc_idx <= 2'h0;
    end else if (t_q != T_RDY[3:0] || ready_in) begin
      t_q <= (t_q == T_END[3:0]) ? 4'h0 : t_q + 4'h1;
      if (t_q == T_END[3:0]) begin
        mc_idx <= (mc_idx == 2'h2) ? 2'h0 : mc_idx + 2'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prot_q <= 1'b0;
      mem_byte <= 8'h00;
    end else begin
      if (protect_line) begin
        prot_q <= 1'b1;
      end else if (unprotect_line) begin
        prot_q <= 1'b0;
      end
      if (wr_req && !prot_q) begin
        mem_byte <= wr_data;
      end
    end
  end
endmodule // fprc_cpu_model
`default_nettype wire

// file: dv/tb_fprc_top.sv
// Self-checking bench for the front panel run control.
// Assumes the processor model answers the bus status pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected t=%0t got %0h exp %0h", $time, g, e); end end
module tb_fprc_top;
  localparam int SLOW_DIV = 30;
  localparam int PANEL_CYC = 2;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic [6:0]  sw = '0;
  logic [7:0]  op_sw = '0;
  logic        jmp_a = 1'b1;
  logic        jmp_b = 1'b1;
  logic        ld_en = 1'b0;
  logic [7:0]  ld_addr = '0;
  logic [7:0]  ld_data = '0;
  logic        wr_req = 1'b0;
  logic [7:0]  wr_data = '0;
  logic        run, panel_ready, switch_enable, step_active, bus_reset;
  logic        b5, sync, strobe, protect_line, unprotect_line;
  logic        seq_busy, jam_valid, slow_tick, pt;
  logic [3:0]  seq_addr_high, seq_addr_low;
  logic [7:0]  ctrl_latch, jam_data, mem_byte, w, j;
  logic [1:0]  mc_idx;
  logic [15:0] mcycles, m0;
  logic [31:0] seed = 32'hfc06aefd;
  logic [6:0]  obs;
  int          err_total = 0;
  int          n_tests = 0;
  int          r;

  assign obs = {slow_tick, seq_busy, jam_valid, bus_reset, step_active,
                switch_enable, run};
  always #20 ref_clk = ~ref_clk;

  fprc_top #(.PANEL_TICK_CYC(PANEL_CYC), .SLOW_TICK_DIV(SLOW_DIV)) i_fprc_top (
    .ref_clk(ref_clk), .reset(reset), .stop_sw(sw[0]), .run_sw(sw[1]),
    .step_sw(sw[2]), .slow_sw(sw[3]), .reset_sw(sw[4]),
    .protect_sw(sw[5]), .unprotect_sw(sw[6]), .op_sw(op_sw),
    .status_bit_five(b5), .cycle_sync(sync), .status_strobe(strobe),
    .status_gate_jumper_a(jmp_a), .status_gate_jumper_b(jmp_b),
    .seq_load_en(ld_en), .seq_load_addr(ld_addr), .seq_load_data(ld_data),
    .run(run), .panel_ready(panel_ready), .switch_enable(switch_enable),
    .step_active(step_active), .bus_reset(bus_reset),
    .protect_line(protect_line), .unprotect_line(unprotect_line),
    .seq_addr_high(seq_addr_high), .seq_addr_low(seq_addr_low),
    .seq_busy(seq_busy), .ctrl_latch(ctrl_latch), .jam_data(jam_data),
    .jam_valid(jam_valid), .panel_tick(pt), .slow_tick(slow_tick));

  fprc_cpu_model i_fprc_cpu_model (
    .ref_clk(ref_clk), .reset(reset), .panel_ready(panel_ready),
    .bus_reset(bus_reset), .protect_line(protect_line),
    .unprotect_line(unprotect_line), .wr_req(wr_req), .wr_data(wr_data),
    .status_bit_five(b5), .cycle_sync(sync), .status_strobe(strobe),
    .mc_idx(mc_idx), .mcycles(mcycles), .mem_byte(mem_byte));

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  // One step spans a whole instruction with both jumpers fitted, else one cycle
  function automatic logic [15:0] exp_mc(input int k);
    return (k == 0) ? 16'h0003 : 16'h0001;
  endfunction
  function automatic logic [7:0] seq_start(input int i);
    return {fprc_pkg::OP_CODE[i], 4'h0};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic set_sw(input int k, input logic v);
    @(posedge ref_clk);
    sw[k] <= v;
    tick(12);
  endtask
  task automatic wait_lvl(input int k, input logic v, input int lim);
    int c = 0;
    do begin
      @(posedge ref_clk);
      #1;
      c++;
    end while (obs[k] !== v && c < lim);
    `CHK(obs[k], v)
  endtask
  task automatic load(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    ld_en <= 1'b1;
    ld_addr <= a;
    ld_data <= d;
    @(posedge ref_clk);
    ld_en <= 1'b0;
    tick(1);
  endtask
  task automatic mem_wr(input logic [7:0] d);
    @(posedge ref_clk);
    wr_req <= 1'b1;
    wr_data <= d;
    @(posedge ref_clk);
    wr_req <= 1'b0;
    tick(2);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    tick(20000);
    err_total++;
    end_of_test();
  end

  initial begin
    tick(20);
    reset <= 1'b0;
    tick(4);
    r = 0;
    repeat (20) begin
      @(posedge ref_clk);
      #1;
      r += pt;
    end
    `CHK(r, 20 / PANEL_CYC)
    @(posedge ref_clk);
    sw[2] <= 1'b1;
    sw[5] <= 1'b1;
    tick(12);
    `CHK(step_active, 1'b0)
    `CHK(protect_line, 1'b0)
    sw <= '0;
    tick(12);
    $display("test refuse done");
    @(posedge ref_clk);
    sw[0] <= 1'b1;
    wait_lvl(1, 1'b1, 200);
    set_sw(0, 1'b0);
    `CHK(run, 1'b0)
    `CHK(panel_ready, 1'b0)
    `CHK(mc_idx, 2'h0)
    m0 = mcycles;
    tick(60);
    `CHK(mcycles, m0)
    `CHK(switch_enable, 1'b1)
    $display("test stop done");
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      jmp_a <= (k == 0 || k == 2);
      jmp_b <= (k == 0 || k == 1);
      sw[2] <= 1'b1;
      m0 = mcycles;
      wait_lvl(2, 1'b1, 40);
      `CHK(panel_ready, 1'b1)
      wait_lvl(2, 1'b0, 100);
      tick(20);
      `CHK(mcycles - m0, exp_mc(k))
      set_sw(2, 1'b0);
    end
    $display("test step done");
    @(posedge ref_clk);
    jmp_a <= 1'b1;
    jmp_b <= 1'b1;
    sw[3] <= 1'b1;
    tick(20);
    wait_lvl(6, 1'b1, 100);
    m0 = mcycles;
    repeat (4) wait_lvl(6, 1'b1, 100);
    tick(40);
    `CHK(mcycles - m0, 16'h000f)
    set_sw(3, 1'b0);
    tick(100);
    m0 = mcycles;
    tick(130);
    `CHK(mcycles, m0)
    $display("test slow done");
    @(posedge ref_clk);
    sw[5] <= 1'b1;
    tick(12);
    `CHK({protect_line, unprotect_line}, 2'b10)
    set_sw(5, 1'b0);
    w = rnd() | 8'h01;
    mem_wr(w);
    `CHK(mem_byte, 8'h00)
    @(posedge ref_clk);
    sw[6] <= 1'b1;
    tick(12);
    `CHK({protect_line, unprotect_line}, 2'b01)
    set_sw(6, 1'b0);
    mem_wr(w);
    `CHK(mem_byte, w)
    $display("test protect done");
    w = rnd();
    r = int'(w[2:0]);
    for (int i = 0; i < 8; i++) load(seq_start(i), 8'h7f);
    w = rnd() | 8'h01;
    if (w == 8'h7f) w = 8'hff;
    j = rnd();
    if (j == 8'h7f) j = 8'h00;
    load(seq_start(r), w);
    load(seq_start(r) + 8'h01, j);
    load(seq_start(r) + 8'h02, 8'h7f);
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      op_sw <= 8'h01 << i;
      wait_lvl(5, 1'b1, 40);
      `CHK(seq_addr_high, fprc_pkg::OP_CODE[i])
      `CHK(seq_addr_low, 4'h0)
      if (i == r) begin
        wait_lvl(4, 1'b1, 20);
        `CHK(ctrl_latch, w)
        `CHK(jam_data, j)
      end
      wait_lvl(5, 1'b0, 100);
      `CHK(seq_addr_low, (i == r) ? 4'h2 : 4'h0)
      @(posedge ref_clk);
      op_sw <= 8'h00;
      tick(12);
    end
    $display("test sequence done");
    set_sw(1, 1'b1);
    set_sw(1, 1'b0);
    `CHK(switch_enable, 1'b0)
    @(posedge ref_clk);
    sw[4] <= 1'b1;
    wait_lvl(3, 1'b1, 30);
    tick(2);
    `CHK(mc_idx, 2'h0)
    set_sw(4, 1'b0);
    wait_lvl(3, 1'b0, 30);
    $display("test reset done");
    end_of_test();
  end
endmodule // tb_fprc_top
`default_nettype wire
